// File: logic/irr_line_filter.sv
// one request line: pin synchroniser, merge and two-sample hysteresis
`timescale 1ns/1ps

module irr_line_filter
    import irr_pkg::*;
(
    input  wire logic clk_sys,     // system clock, sampled on falling edge
    input  wire logic rst_n,       // synchronised reset, active low
    input  wire logic clk_en,      // freezes the filter while low
    input  wire logic pin_req_n,   // external request pin, asynchronous
    input  wire logic pin_enable,  // pin routed to the request function
    input  wire logic mod_req_n,   // internal module request, same clock
    output logic      req_valid    // filtered request, active high
);

    irr_filt_t st_reg;    // registered filter state
    irr_filt_t st_next;   // next filter state
    logic      merged;    // request on the shared internal line

    // merge the pin with the internal line, then filter
    always_comb
    begin
        st_next       = st_reg;
        // the pin counts only once it has passed both stages
        merged        = ~mod_req_n | (pin_enable & ~st_reg.sync2);
        st_next.sync1 = pin_req_n;
        st_next.sync2 = st_reg.sync1;
        st_next.prev  = merged;
        // valid only when seen at two consecutive samples
        st_next.valid = st_reg.prev & merged;
    end

    // samples are taken on successive falling clock edges
    always_ff @(negedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b0, valid: 1'b0};
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    assign req_valid = st_reg.valid;

    // a request becomes valid only after two asserted samples
    a_hyst_two_samples:
    assert property (@(negedge clk_sys) disable iff (!rst_n)
        $rose(st_reg.valid) |-> $past(st_reg.prev))
    else $error("request valid without two asserted samples");

endmodule

// File: logic/irr_params.svh
// constants for the interrupt request recognition block
`ifndef IRR_PARAMS_SVH
`define IRR_PARAMS_SVH

// number of request lines, levels one to seven
`define IRR_NUM_LINES   7
// priority mask value after reset (all maskable levels masked)
`define IRR_MASK_RESET  3'h7
// mask value that blocks every maskable level
`define IRR_MASK_ALL    3'h7
// the non-maskable level
`define IRR_LEVEL_NMI   3'h7
// code meaning no request qualifies
`define IRR_LEVEL_NONE  3'h0

`endif

// File: logic/irr_pkg.sv
// types shared by the interrupt request recognition design
package irr_pkg;

    // state of one request line filter
    typedef struct packed {
        logic sync1;   // first synchroniser stage of the pin
        logic sync2;   // second synchroniser stage of the pin
        logic prev;    // merged request seen at the previous sample
        logic valid;   // request held for two consecutive samples
    } irr_filt_t;

    // state of the recognition logic
    typedef struct packed {
        logic [2:0] mask;        // current priority mask
        logic [2:0] mask_d;      // mask one cycle earlier
        logic       valid7_d;    // level seven valid one cycle earlier
        logic       nmi_pend;    // non-maskable request waiting
        logic [2:0] pend_level;  // level offered to the core
        logic       pending;     // some level is offered
        logic [2:0] ack_level;   // level driven during acknowledge
        logic       ack_strobe;  // acknowledge taken this cycle
        logic       nmi_event;   // new non-maskable request raised
    } irr_state_t;

endpackage

// File: logic/irr_recognition.sv
// interrupt request recognition: filtering, masking, pending, acknowledge
`timescale 1ns/1ps
//
// Contract
// - three-bit priority mask, values zero to seven
// - seven active-low lines, one lowest, seven highest
// - levels at or below mask are ignored
// - level seven recognised even at mask seven
// - level seven needs a falling edge
// - new level seven on assertion or mask drop
// - lines sampled on consecutive falling clock edges
// - valid after two consecutive asserted periods
// - requests wait for an instruction boundary
// - pending level not latched; higher one wins
// - simultaneous requests above mask: higher wins
// - pin requests merged onto internal lines
// - acknowledge drives level and loads the mask

`include "irr_params.svh"

module irr_recognition
    import irr_pkg::*;
#(
    parameter int NUM_LINES = `IRR_NUM_LINES  // request lines, level 1 up
)
(
    input  wire logic                 clk_sys,        // 50 MHz system clock
    input  wire logic                 reset_n,        // async reset, low
    input  wire logic                 clk_en,         // freezes state if low
    input  wire logic [NUM_LINES:1]   irq_pin_n,      // external pins, low
    input  wire logic [NUM_LINES:1]   pin_enable,     // pin as request
    input  wire logic [NUM_LINES:1]   irq_mod_n,      // module lines, low
    input  wire logic                 instr_boundary, // core may take one
    input  wire logic                 mask_wr,        // core writes mask
    input  wire logic [2:0]           mask_wdata,     // mask to write
    output logic [2:0]                priority_mask_field, // current mask
    output logic [2:0]                pending_level,  // level offered
    output logic                      irq_pending,    // a level offered
    output logic [2:0]                ack_addr,       // level on addr 3..1
    output logic                      ack_strobe,     // acknowledge pulse
    output logic                      nmi_event       // new level seven
);

    logic                rst_sync1;  // reset release, first stage
    logic                rst_n_sync; // reset release, second stage
    logic [NUM_LINES:1]  req_valid;  // filtered requests, active high
    irr_state_t          st_reg;     // registered recognition state
    irr_state_t          st_next;    // next recognition state
    logic                nmi_rise;   // level seven newly asserted
    logic                mask_drop;  // mask left seven with seven held
    logic [2:0]          best;       // highest qualifying level

    // reset is asserted at once and released through two flops
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync1  <= 1'b0;
            rst_n_sync <= 1'b0;
        end
        else
        begin
            rst_sync1  <= 1'b1;
            rst_n_sync <= rst_sync1;
        end
    end

    // one filter per request line, line i feeds level i
    genvar gi;
    generate
        for (gi = 1; gi <= NUM_LINES; gi++)
        begin : g_line
            irr_line_filter u_filter (
                .clk_sys    (clk_sys),
                .rst_n      (rst_n_sync),
                .clk_en     (clk_en),
                .pin_req_n  (irq_pin_n[gi]),
                .pin_enable (pin_enable[gi]),
                .mod_req_n  (irq_mod_n[gi]),
                .req_valid  (req_valid[gi])
            );
        end
    endgenerate

    // next state: mask, level seven edge, level selection, acknowledge
    always_comb
    begin
        st_next            = st_reg;
        best               = `IRR_LEVEL_NONE;
        st_next.ack_strobe = 1'b0;
        st_next.nmi_event  = 1'b0;
        st_next.mask_d     = st_reg.mask;
        st_next.valid7_d   = req_valid[NUM_LINES];
        // level seven counts only on its assertion edge
        nmi_rise  = req_valid[NUM_LINES] & ~st_reg.valid7_d;
        // mask lowered from seven while level seven still held
        mask_drop = (st_reg.mask_d == `IRR_MASK_ALL)
                    && (st_reg.mask != `IRR_MASK_ALL)
                    && req_valid[NUM_LINES];

        // core rewrites the mask (three bits, any of eight values)
        if (mask_wr)
        begin
            st_next.mask = mask_wdata;
        end

        // take the offered level at an instruction boundary
        if (instr_boundary && st_reg.pending)
        begin
            st_next.ack_level  = st_reg.pend_level;
            st_next.ack_strobe = 1'b1;
            st_next.mask       = st_reg.pend_level;
            if (st_reg.pend_level == `IRR_LEVEL_NMI)
            begin
                st_next.nmi_pend = 1'b0;
            end
        end

        // a new level seven wins over a clear in the same cycle
        if (nmi_rise || mask_drop)
        begin
            st_next.nmi_pend  = 1'b1;
            st_next.nmi_event = 1'b1;
        end

        // highest maskable level above the mask, recomputed each cycle
        for (int i = 1; i < NUM_LINES; i++)
        begin
            // sources hold their line until acknowledged, so no latch
            if (req_valid[i] && (3'(i) > st_next.mask))
            begin
                best = 3'(i);
            end
        end
        // level seven ignores the mask once raised by its edge
        if (st_next.nmi_pend)
        begin
            best = `IRR_LEVEL_NMI;
        end
        st_next.pend_level = best;
        st_next.pending    = (best != `IRR_LEVEL_NONE);
    end

    // register the state; clock enable holds everything
    always_ff @(posedge clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            st_reg <= '{mask:       `IRR_MASK_RESET,
                        mask_d:     `IRR_MASK_RESET,
                        valid7_d:   1'b0,
                        nmi_pend:   1'b0,
                        pend_level: `IRR_LEVEL_NONE,
                        pending:    1'b0,
                        ack_level:  `IRR_LEVEL_NONE,
                        ack_strobe: 1'b0,
                        nmi_event:  1'b0};
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // outputs come straight from the state register
    assign priority_mask_field = st_reg.mask;
    assign pending_level       = st_reg.pend_level;
    assign irq_pending         = st_reg.pending;
    assign ack_addr            = st_reg.ack_level;
    assign ack_strobe          = st_reg.ack_strobe;
    assign nmi_event           = st_reg.nmi_event;

    // acknowledge drives the taken level and loads it as mask
    a_ack_loads_mask:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && instr_boundary && st_reg.pending
        |=> ack_strobe && (ack_addr == $past(st_reg.pend_level))
            && (priority_mask_field == $past(st_reg.pend_level)))
    else $error("acknowledge did not drive level or load mask");

    // a maskable level offered is always above the mask
    a_above_mask_only:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        (pending_level != 3'h0) && (pending_level != 3'h7)
        |-> pending_level > priority_mask_field)
    else $error("offered level not above mask");

    // a waiting level seven is offered whatever the mask
    a_nmi_offers_seven:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        st_reg.nmi_pend |-> (pending_level == 3'h7) && irq_pending)
    else $error("level seven not offered while waiting");

    // assertion edge of level seven raises a new request
    a_nmi_edge_set:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && req_valid[7] && !st_reg.valid7_d
        |=> st_reg.nmi_pend && nmi_event)
    else $error("level seven edge did not raise a request");

    // no new level seven while its line is released, so with no edge and no mask drop
    a_nmi_needs_cause:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && !req_valid[7] |=> !nmi_event)
    else $error("level seven raised with line released");

    // mask leaving seven with level seven held raises a request
    a_mask_drop_nmi:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && (st_reg.mask_d == 3'h7) && (st_reg.mask != 3'h7)
        && req_valid[7] |=> st_reg.nmi_pend)
    else $error("mask drop did not raise level seven");

    // a valid level six above the mask beats lower levels
    a_higher_wins:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && req_valid[6] && !mask_wr && !instr_boundary
        && (priority_mask_field < 3'h6) |=> pending_level >= 3'h6)
    else $error("higher level request not offered");

    // nothing is acknowledged away from an instruction boundary
    a_wait_boundary:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && !instr_boundary |=> !ack_strobe)
    else $error("acknowledge without instruction boundary");

    // a mask write away from an acknowledge lands as written
    a_mask_write_lands:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && mask_wr && !(instr_boundary && st_reg.pending)
        |=> priority_mask_field == $past(mask_wdata))
    else $error("mask write did not land");

    // a maskable level is offered only while its line is valid
    a_offer_is_valid:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && (st_next.pend_level != 3'h0)
        && (st_next.pend_level != 3'h7)
        |-> req_valid[st_next.pend_level])
    else $error("offered level has no valid request");

    // with the mask at seven and no new cause nothing is offered
    a_full_mask_silent:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && !mask_wr && !instr_boundary && !st_reg.nmi_pend
        && (st_reg.mask_d == 3'h7) && (priority_mask_field == 3'h7)
        && (req_valid[7] == st_reg.valid7_d)
        |=> !irq_pending)
    else $error("request offered through a full mask");

    // level five is offered over lower ones when it leads
    a_held_level_wins:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && !mask_wr && !instr_boundary && !st_reg.nmi_pend
        && !req_valid[7] && !req_valid[6] && req_valid[5]
        && (priority_mask_field < 3'h5)
        |=> pending_level == 3'h5)
    else $error("leading level five not offered");

    // a taken level seven is cleared unless a new cause arrives
    a_nmi_clear_ack:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && instr_boundary && st_reg.pending
        && (st_reg.pend_level == 3'h7) && !nmi_rise && !mask_drop
        |=> !st_reg.nmi_pend)
    else $error("level seven still waiting after acknowledge");

    // back-to-back acknowledges never step down in level
    a_ack_no_step_down:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && ack_strobe
        |=> !ack_strobe || (ack_addr >= $past(ack_addr)))
    else $error("second acknowledge below the first");

    // nothing is acknowledged while no level is offered
    a_no_ack_idle:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && !irq_pending |=> !ack_strobe)
    else $error("acknowledge with no level offered");

    // the acknowledged level stands until the next acknowledge
    a_ack_addr_holds:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && !(instr_boundary && irq_pending)
        |=> $stable(ack_addr))
    else $error("acknowledge address moved without acknowledge");

    // a low clock enable freezes the mask, level, strobe and event outputs
    a_enable_freezes:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        !clk_en |=> $stable(priority_mask_field) && $stable(pending_level)
            && $stable(ack_strobe) && $stable(nmi_event))
    else $error("state moved while clock enable was low");

    // a lowered mask with level seven held raises the event pulse
    a_drop_event:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && mask_drop |=> nmi_event)
    else $error("mask drop raised no event");

    // with no valid line and no waiting level seven the offer falls back to zero
    a_idle_offers_zero:
    assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
        clk_en && !st_reg.nmi_pend && (req_valid == '0)
        |=> (pending_level == 3'h0) && !irq_pending)
    else $error("level offered with no valid request");

endmodule

// File: testbench/irr_source_model.sv
// source model: module request lines held low until acknowledged
`timescale 1ns/1ps

module irr_source_model
(
    input  wire logic       clk_sys,    // system clock
    input  wire logic [7:1] raise,      // command to assert a level
    input  wire logic       ack_strobe, // acknowledge pulse from block
    input  wire logic [2:0] ack_addr,   // acknowledged level
    output logic      [7:1] irq_mod_n   // request lines, active low
);
    // lines start released, nothing requested
    initial irq_mod_n = 7'h7f;

    // lines move on the falling edge like the internal modules
    always @(negedge clk_sys)
    begin
        for (int i = 1; i <= 7; i++)
        begin
            // a raised line stays low as a level
            if (raise[i])
                irq_mod_n[i] <= 1'b0;
            // released only by an acknowledge at its own level
            else if (ack_strobe === 1'b1 && ack_addr == i[2:0])
                irq_mod_n[i] <= 1'b1;
        end
    end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the interrupt request recognition block
`timescale 1ns/1ps

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end

module testbench;
    logic       clk_sys = 0;       // 50 MHz clock
    logic       reset_n = 0;       // reset, active low
    logic [7:1] irq_pin_n = 7'h7f; // external pins
    logic [7:1] pin_enable = 0;    // pin routing
    logic [7:1] irq_mod_n;         // module lines from the model
    logic [7:1] raise = 0;         // model commands
    logic       instr_boundary = 0; // core boundary
    logic       clk_en = 1;        // clock enable
    logic       mask_wr = 0;       // mask write strobe
    logic [2:0] mask_wdata = 0;    // mask to write
    logic [2:0] mask, lvl, ack_addr; // block outputs
    logic       irq_pending, ack_strobe, nmi_event;
    logic [3:0] notes[$];          // expected acks, 8 marks a new nmi
    logic [3:0] nt;                // note taken by the watcher
    int         n_mismatch = 0;    // mismatches
    int         n_tests = 0;       // comparisons
    int         cyc = 0;           // cycle counter for the hang limit
    int         l;                 // random level

    always #10 clk_sys = ~clk_sys;

    irr_recognition uut (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .irq_pin_n(irq_pin_n), .pin_enable(pin_enable),
        .irq_mod_n(irq_mod_n), .instr_boundary(instr_boundary),
        .mask_wr(mask_wr), .mask_wdata(mask_wdata),
        .priority_mask_field(mask), .pending_level(lvl),
        .irq_pending(irq_pending), .ack_addr(ack_addr),
        .ack_strobe(ack_strobe), .nmi_event(nmi_event));

    irr_source_model src (.clk_sys(clk_sys), .raise(raise),
        .ack_strobe(ack_strobe), .ack_addr(ack_addr),
        .irq_mod_n(irq_mod_n));

    // watcher: each cycle with a pulse takes the oldest note, empty means none due
    always @(negedge clk_sys)
    begin
        if (ack_strobe === 1'b1 || nmi_event === 1'b1)
        begin
            nt = notes.size() ? notes.pop_front() : 4'hf;
            if (ack_strobe === 1'b1)
                `CHK({1'b0, ack_addr}, nt)
            else
                `CHK(4'h8, nt)
        end
    end

    // hang limit, well above the expected run length
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one-cycle mask write from the core
    task automatic setmask(input logic [2:0] m);
        @(negedge clk_sys);
        mask_wr <= 1'b1;
        mask_wdata <= m;
        @(negedge clk_sys);
        mask_wr <= 1'b0;
    endtask

    // model raises the given levels
    task automatic up(input logic [7:1] v);
        @(negedge clk_sys);
        raise <= v;
        @(negedge clk_sys);
        raise <= 0;
    endtask

    // boundary pulse; an expected level is noted first
    task automatic take(input logic [3:0] e);
        if (e != 4'hf)
            notes.push_back(e);
        @(negedge clk_sys);
        instr_boundary <= 1'b1;
        @(negedge clk_sys);
        instr_boundary <= 1'b0;
        wt(4);
    endtask

    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(88490));
        wt(5);
        reset_n <= 1'b1;
        wt(3);
        `CHK(mask, 3'h7)
        `CHK(lvl, 3'h0)
        $display("reset values done");
        // every mask below seven against a random level
        for (int m = 0; m < 7; m++)
        begin
            l = 1 + $urandom % 6;
            setmask(m[2:0]);
            up(7'h1 << (l - 1));
            wt(6);
            `CHK(irq_pending, (l > m))
            if (l <= m)
            begin
                take(4'hf); // refused: nothing offered
                setmask(3'h0);
                wt(6);
            end
            take(l[3:0]);
            `CHK(mask, l[2:0])
        end
        $display("mask sweep done");
        // two levels at once, then a higher one over a pending lower
        setmask(3'h0);
        up(7'h12);
        wt(6);
        `CHK(lvl, 3'h5)
        take(4'h5);
        setmask(3'h0);
        wt(6);
        `CHK(lvl, 3'h2)
        up(7'h20);
        wt(6);
        `CHK(lvl, 3'h6)
        take(4'h6);
        setmask(3'h0);
        wt(4);
        take(4'h2);
        $display("priority order done");
        // clock enable low: a raised level waits until enable returns
        clk_en <= 1'b0;
        up(7'h04);
        wt(6);
        `CHK(irq_pending, 1'b0)
        clk_en <= 1'b1;
        wt(6);
        `CHK(lvl, 3'h3)
        take(4'h3);
        $display("clock enable done");
        // pin path: one-sample glitch, disabled pin, enabled pin
        setmask(3'h0);
        pin_enable <= 7'h08;
        irq_pin_n[4] <= 1'b0;
        wt(1);
        irq_pin_n[4] <= 1'b1;
        wt(8);
        `CHK(irq_pending, 1'b0)
        pin_enable <= 7'h00;
        irq_pin_n[4] <= 1'b0;
        wt(8);
        `CHK(irq_pending, 1'b0)
        pin_enable <= 7'h48;
        wt(8);
        `CHK(lvl, 3'h4)
        take(4'h4);
        irq_pin_n[4] <= 1'b1;
        $display("pin path done");
        // level seven at full mask, held, then unmasked by a mask drop
        setmask(3'h7);
        notes.push_back(4'h8);
        irq_pin_n[7] <= 1'b0;
        wt(8);
        `CHK(lvl, 3'h7)
        take(4'h7);
        wt(6);
        `CHK(lvl, 3'h0)
        notes.push_back(4'h8);
        setmask(3'h3);
        wt(6);
        `CHK(lvl, 3'h7)
        take(4'h7);
        irq_pin_n[7] <= 1'b1;
        wt(4);
        `CHK(notes.size(), 0)
        $display("level seven done");
        conclude();
    end
endmodule
